// [hw/eag_pkg.sv]
// Constants, offsets, fields and modes of the effective address generator
// Assumes one core clock and a decoder issuing one request per cycle
package eag_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [4:0] OFS_STACK_LIMIT = 5'h00;
    localparam logic [4:0] OFS_X_CIRC_START = 5'h04;
    localparam logic [4:0] OFS_X_CIRC_END = 5'h08;
    localparam logic [4:0] OFS_Y_CIRC_START = 5'h0C;
    localparam logic [4:0] OFS_Y_CIRC_END = 5'h10;
    localparam logic [4:0] OFS_CIRC_CONTROL = 5'h14;
    localparam logic [4:0] OFS_SECURE_CTRL = 5'h18;
    localparam logic [4:0] OFS_STACK_PTR = 5'h1C;
    // ==========================================================
    // Field positions
    localparam int CC_X_EN_BIT = 15;
    localparam int CC_Y_EN_BIT = 14;
    localparam int CC_XSEL_LO = 0;
    localparam int CC_YSEL_LO = 4;
    localparam int SEC_BOOT_EN_BIT = 0;
    localparam int SEC_SEG_EN_BIT = 1;
    // ==========================================================
    // Reset values and fixed figures
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h0800;
    localparam logic [15:0] CC_RESET = 16'h00FF;
    localparam logic [15:0] UNDERFLOW_LIMIT = 16'h0800;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [3:0] SP_REG = 4'hF;
    localparam logic [3:0] NO_CIRC_SEL = 4'hF;
    localparam logic [3:0] X_PREFETCH_B = 4'h9;
    localparam logic [3:0] Y_PREFETCH_A = 4'hA;
    localparam logic [3:0] Y_PREFETCH_B = 4'hB;
    localparam logic [1:0] DUAL_SET_TOP = 2'b10;
    localparam logic [15:0] DUAL_STEP_2 = 16'h0002;
    localparam logic [15:0] DUAL_STEP_4 = 16'h0004;
    localparam logic [15:0] DUAL_STEP_6 = 16'h0006;
    localparam int NEAR_FIELD_W = 13;
    localparam int LIT5_W = 5;
    localparam int LIT8_W = 8;
    localparam int IRQ_DIS_W = 14;
    localparam logic [15:0] BOOT_RAM_LO = 16'h0800;
    localparam logic [15:0] BOOT_RAM_HI = 16'h08FF;
    localparam logic [15:0] SEG_RAM_LO = 16'h0900;
    localparam logic [15:0] SEG_RAM_HI = 16'h09FF;
    // ==========================================================
    // Modes
    typedef enum logic [3:0] {
        MD_FILE, MD_REG, MD_IND, MD_POST, MD_PRE, MD_REGOFS, MD_LITOFS,
        MD_LIT5, MD_LIT8, MD_LIT16, MD_BRANCH, MD_IRQ_DIS,
        MD_DUAL_IND, MD_DUAL_POST, MD_DUAL_IDX
    } eag_mode_t;
    typedef enum logic [1:0] {STK_NONE, STK_PUSH, STK_POP} eag_stack_t;
    typedef enum logic [1:0] {
        PUSH_OPERAND, PUSH_PC_LOW, PUSH_PC_CALL, PUSH_PC_EXC
    } eag_push_t;
endpackage

// [hw/eag_core.sv]
// Effective address generator with stack limit checks and circular buffers
// Assumes decoder and data memory on the same clock; Avalon-MM registers
`timescale 1ns/1ps
module eag_core
    import eag_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [4:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    input wire logic reqValid,
    input wire eag_mode_t reqMode,
    input wire eag_stack_t reqStack,
    input wire eag_push_t reqPushSrc,
    input wire logic [3:0] reqPtr,
    input wire logic [3:0] reqIdx,
    input wire logic [15:0] reqField,
    input wire logic [15:0] reqOperand,
    input wire logic [23:0] pcValue,
    input wire logic [7:0] statusLow,
    input wire logic codeInBoot,
    input wire logic codeInSecure,
    input wire logic regWrValid,
    input wire logic [3:0] regWrIdx,
    input wire logic [15:0] regWrData,
    output logic eaValid,
    output logic [15:0] eaAddr,
    output logic eaSpaceY,
    output logic eaDenied,
    output logic [15:0] pushData,
    output logic opValid,
    output logic [15:0] opValue,
    output logic stackErrTrap,
    output logic modeError
);
    // ==========================================================
    // Helpers
    function automatic logic [15:0] eag_wrap(
        input logic [15:0] a, input logic [15:0] lo,
        input logic [15:0] hi, input logic on, input logic wordOnly);
        logic [15:0] len;
        logic [15:0] r;
        len = hi - lo + 16'h0001;
        r = a;
        if (on && a > hi)
            r = a - len;
        else if (on && a < lo)
            r = a + len;
        if (wordOnly)
            r[0] = 1'b0;
        return r;
    endfunction

    function automatic logic eag_in(
        input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // ==========================================================
    // Register storage
    logic [15:0] regs [16];
    logic [15:0] stackLimit;
    logic [15:0] xCircStart;
    logic [15:0] xCircEnd;
    logic [15:0] yCircStart;
    logic [15:0] yCircEnd;
    logic [15:0] circControl;
    logic [1:0] secureCtrl;
    logic busAck;
    logic wbEn;
    logic [15:0] wbVal;
    logic [3:0] wbIdx;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_regs
            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    regs[gi] <= (gi == 15) ? SP_RESET : REG_RESET;
                else if (wbEn && wbIdx == 4'(gi))
                    regs[gi] <= wbVal;
                else if (regWrValid && regWrIdx == 4'(gi))
                    regs[gi] <= regWrData;
            end
        end
    endgenerate

    // ==========================================================
    // Avalon slave
    logic busWr;
    logic [15:0] wrMerged;
    logic [15:0] curVal;

    assign avsWaitrequest = (avsRead || avsWrite) && !busAck;
    assign busWr = avsWrite && busAck;

    always_comb
    begin
        case (avsAddress)
            OFS_STACK_LIMIT: curVal = stackLimit;
            OFS_X_CIRC_START: curVal = xCircStart;
            OFS_X_CIRC_END: curVal = xCircEnd;
            OFS_Y_CIRC_START: curVal = yCircStart;
            OFS_Y_CIRC_END: curVal = yCircEnd;
            OFS_CIRC_CONTROL: curVal = circControl;
            OFS_SECURE_CTRL: curVal = {14'h0000, secureCtrl};
            OFS_STACK_PTR: curVal = regs[SP_REG];
            default: curVal = 16'h0000;
        endcase
        wrMerged[7:0] = avsByteenable[0] ? avsWritedata[7:0] : curVal[7:0];
        wrMerged[15:8] = avsByteenable[1] ? avsWritedata[15:8] : curVal[15:8];
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            busAck <= 1'b0;
        else
            busAck <= (avsRead || avsWrite) && !busAck;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            avsReaddata <= 32'h0000_0000;
        else if (avsRead && !busAck)
            avsReaddata <= {16'h0000, curVal};
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            stackLimit <= REG_RESET;
            xCircStart <= REG_RESET;
            xCircEnd <= REG_RESET;
            yCircStart <= REG_RESET;
            yCircEnd <= REG_RESET;
            circControl <= CC_RESET;
            secureCtrl <= 2'b00;
        end
        else if (busWr)
        begin
            case (avsAddress)
                OFS_STACK_LIMIT: stackLimit <= {wrMerged[15:1], 1'b0};
                OFS_X_CIRC_START: xCircStart <= wrMerged;
                OFS_X_CIRC_END: xCircEnd <= wrMerged;
                OFS_Y_CIRC_START: yCircStart <= wrMerged;
                OFS_Y_CIRC_END: yCircEnd <= wrMerged;
                OFS_CIRC_CONTROL: circControl <= wrMerged;
                OFS_SECURE_CTRL: secureCtrl <= wrMerged[1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Address calculation
    logic [15:0] sp;
    logic [15:0] base;
    logic [15:0] idxVal;
    logic xCirc;
    logic yCirc;
    logic dualSet;
    logic dualY;
    logic stepOk;
    logic next_eaValid;
    logic [15:0] next_eaAddr;
    logic next_spaceY;
    logic next_spUse;
    logic next_opValid;
    logic [15:0] next_opValue;
    logic [15:0] next_push;
    logic next_modeError;
    logic next_denied;
    logic next_trap;
    logic eaFromSp;

    assign sp = regs[SP_REG];
    assign base = regs[reqPtr];
    assign wbIdx = (reqStack == STK_NONE) ? reqPtr : SP_REG;
    assign idxVal = regs[reqIdx];
    assign xCirc = circControl[CC_X_EN_BIT]
        && circControl[CC_XSEL_LO +: 4] != NO_CIRC_SEL
        && circControl[CC_XSEL_LO +: 4] == reqPtr;
    assign yCirc = circControl[CC_Y_EN_BIT]
        && circControl[CC_YSEL_LO +: 4] != NO_CIRC_SEL
        && circControl[CC_YSEL_LO +: 4] == reqPtr;
    assign dualSet = reqPtr[3:2] == DUAL_SET_TOP;
    assign dualY = reqPtr == Y_PREFETCH_A || reqPtr == Y_PREFETCH_B;
    assign stepOk = reqField == DUAL_STEP_2 || reqField == DUAL_STEP_4
        || reqField == DUAL_STEP_6;

    always_comb
    begin
        next_eaValid = 1'b0;
        next_eaAddr = 16'h0000;
        next_spaceY = 1'b0;
        next_spUse = 1'b0;
        next_opValid = 1'b0;
        next_opValue = 16'h0000;
        next_push = 16'h0000;
        next_modeError = 1'b0;
        wbEn = 1'b0;
        wbVal = 16'h0000;
        if (!reqValid)
            ;
        else if (reqStack == STK_PUSH)
        begin
            next_eaValid = 1'b1;
            next_spUse = 1'b1;
            next_eaAddr = sp;
            wbEn = 1'b1;
            wbVal = sp + WORD_STEP;
            case (reqPushSrc)
                PUSH_PC_LOW: next_push = pcValue[15:0];
                PUSH_PC_CALL: next_push = {9'h000, pcValue[22:16]};
                PUSH_PC_EXC: next_push = {statusLow, pcValue[23:16]};
                default: next_push = reqOperand;
            endcase
        end
        else if (reqStack == STK_POP)
        begin
            next_eaValid = 1'b1;
            next_spUse = 1'b1;
            wbEn = 1'b1;
            wbVal = sp - WORD_STEP;
            next_eaAddr = sp - WORD_STEP;
        end
        else
        begin
            next_spUse = reqPtr == SP_REG;
            case (reqMode)
                MD_FILE:
                begin
                    next_spUse = 1'b0;
                    next_eaValid = 1'b1;
                    next_eaAddr = {3'b000, reqField[NEAR_FIELD_W-1:0]};
                end
                MD_REG:
                begin
                    next_spUse = 1'b0;
                    next_opValid = 1'b1;
                    next_opValue = base;
                end
                MD_IND:
                begin
                    next_eaValid = 1'b1;
                    next_eaAddr = base;
                end
                MD_POST:
                begin
                    next_eaValid = 1'b1;
                    next_eaAddr = base;
                    wbEn = 1'b1;
                    wbVal = eag_wrap(base + reqField, xCircStart, xCircEnd,
                        xCirc, 1'b0);
                end
                MD_PRE:
                begin
                    next_eaValid = 1'b1;
                    wbEn = 1'b1;
                    wbVal = eag_wrap(base + reqField, xCircStart, xCircEnd,
                        xCirc, 1'b0);
                    next_eaAddr = wbVal;
                end
                MD_REGOFS:
                begin
                    next_eaValid = 1'b1;
                    next_eaAddr = eag_wrap(base + idxVal, xCircStart,
                        xCircEnd, xCirc, 1'b0);
                end
                MD_LITOFS:
                begin
                    next_eaValid = 1'b1;
                    next_eaAddr = eag_wrap(base + reqField, xCircStart,
                        xCircEnd, xCirc, 1'b0);
                end
                MD_LIT5:
                begin
                    next_spUse = 1'b0;
                    next_opValid = 1'b1;
                    next_opValue = {11'h000, reqField[LIT5_W-1:0]};
                end
                MD_LIT8:
                begin
                    next_spUse = 1'b0;
                    next_opValid = 1'b1;
                    next_opValue = {8'h00, reqField[LIT8_W-1:0]};
                end
                MD_LIT16, MD_BRANCH:
                begin
                    next_spUse = 1'b0;
                    next_opValid = 1'b1;
                    next_opValue = reqField;
                end
                MD_IRQ_DIS:
                begin
                    next_spUse = 1'b0;
                    next_opValid = 1'b1;
                    next_opValue = {2'b00, reqField[IRQ_DIS_W-1:0]};
                end
                MD_DUAL_IND, MD_DUAL_POST, MD_DUAL_IDX:
                begin
                    next_spUse = 1'b0;
                    next_spaceY = dualY;
                    if (!dualSet)
                        next_modeError = 1'b1;
                    else if (reqMode == MD_DUAL_IND)
                    begin
                        next_eaValid = 1'b1;
                        next_eaAddr = eag_wrap(base, yCircStart, yCircEnd,
                            1'b0, dualY);
                    end
                    else if (reqMode == MD_DUAL_POST && stepOk)
                    begin
                        next_eaValid = 1'b1;
                        next_eaAddr = eag_wrap(base, yCircStart, yCircEnd,
                            1'b0, dualY);
                        wbEn = 1'b1;
                        wbVal = dualY
                            ? eag_wrap(base + reqField, yCircStart, yCircEnd,
                                yCirc, 1'b1)
                            : eag_wrap(base + reqField, xCircStart, xCircEnd,
                                xCirc, 1'b0);
                    end
                    else if (reqMode == MD_DUAL_IDX
                        && (reqPtr == X_PREFETCH_B || reqPtr == Y_PREFETCH_B))
                    begin
                        next_eaValid = 1'b1;
                        next_eaAddr = dualY
                            ? eag_wrap(base + idxVal, yCircStart, yCircEnd,
                                yCirc, 1'b1)
                            : eag_wrap(base + idxVal, xCircStart, xCircEnd,
                                xCirc, 1'b0);
                    end
                    else
                        next_modeError = 1'b1;
                end
                default: next_modeError = 1'b1;
            endcase
        end
        next_denied = next_eaValid
            && ((secureCtrl[SEC_BOOT_EN_BIT] && !codeInBoot
                && eag_in(next_eaAddr, BOOT_RAM_LO, BOOT_RAM_HI))
            || (secureCtrl[SEC_SEG_EN_BIT] && !codeInSecure
                && eag_in(next_eaAddr, SEG_RAM_LO, SEG_RAM_HI)));
        next_trap = next_eaValid && next_spUse
            && (next_eaAddr > stackLimit
            || next_eaAddr < UNDERFLOW_LIMIT);
    end

    // ==========================================================
    // Registered outputs
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            eaValid <= 1'b0;
            eaAddr <= 16'h0000;
            eaSpaceY <= 1'b0;
            eaDenied <= 1'b0;
            eaFromSp <= 1'b0;
            pushData <= 16'h0000;
            opValid <= 1'b0;
            opValue <= 16'h0000;
            stackErrTrap <= 1'b0;
            modeError <= 1'b0;
        end
        else
        begin
            eaValid <= next_eaValid;
            eaAddr <= next_eaAddr;
            eaSpaceY <= next_spaceY;
            eaDenied <= next_denied;
            eaFromSp <= next_eaValid && next_spUse;
            pushData <= next_push;
            opValid <= next_opValid;
            opValue <= next_opValue;
            stackErrTrap <= next_trap;
            modeError <= next_modeError;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_push;
        reqValid && reqStack == STK_PUSH;
    endsequence
    sequence s_pop;
        reqValid && reqStack == STK_POP;
    endsequence

    property p_push_addr;
        s_push |=> eaAddr == $past(sp) && sp == $past(sp) + WORD_STEP;
    endproperty
    a_push_addr: assert property (p_push_addr)
        else $error("push address or increment wrong");

    property p_pop_addr;
        s_pop |=> eaAddr == $past(sp) - WORD_STEP && sp == eaAddr;
    endproperty
    a_pop_addr: assert property (p_pop_addr)
        else $error("pop address or decrement wrong");

    property p_call_msb;
        s_push and reqPushSrc == PUSH_PC_CALL |=> pushData[15:7] == 9'h000;
    endproperty
    a_call_msb: assert property (p_call_msb)
        else $error("call push top bits not clear");

    property p_exc_push;
        s_push and reqPushSrc == PUSH_PC_EXC
            |=> pushData == {$past(statusLow), $past(pcValue[23:16])};
    endproperty
    a_exc_push: assert property (p_exc_push)
        else $error("exception push word wrong");

    property p_limit_lsb;
        busWr && avsAddress == OFS_STACK_LIMIT |=> stackLimit[0] == 1'b0;
    endproperty
    a_limit_lsb: assert property (p_limit_lsb)
        else $error("stack limit bit zero set");

    property p_limit_trap;
        eaValid && eaFromSp |-> stackErrTrap
            == (eaAddr > stackLimit || eaAddr < UNDERFLOW_LIMIT);
    endproperty
    a_limit_trap: assert property (p_limit_trap)
        else $error("stack trap does not match limits");

    property p_underflow;
        s_pop and sp == UNDERFLOW_LIMIT |=> stackErrTrap;
    endproperty
    a_underflow: assert property (p_underflow)
        else $error("underflow not trapped");

    property p_file;
        reqValid && reqStack == STK_NONE && reqMode == MD_FILE
            |=> eaValid && eaAddr[15:13] == 3'b000 && !stackErrTrap;
    endproperty
    a_file: assert property (p_file)
        else $error("file address exceeds near space");

    property p_dual_idx;
        reqValid && reqStack == STK_NONE && reqMode == MD_DUAL_IDX
            && reqPtr != X_PREFETCH_B && reqPtr != Y_PREFETCH_B
            |=> modeError && !eaValid;
    endproperty
    a_dual_idx: assert property (p_dual_idx)
        else $error("dual indexed allowed on wrong pointer");

    property p_secure;
        eaValid && !$past(codeInBoot) && secureCtrl[SEC_BOOT_EN_BIT]
            && $stable(secureCtrl)
            && eag_in(eaAddr, BOOT_RAM_LO, BOOT_RAM_HI) |-> eaDenied;
    endproperty
    a_secure: assert property (p_secure)
        else $error("boot secure access not denied");

    property p_lit5;
        reqValid && reqStack == STK_NONE && reqMode == MD_LIT5
            |=> opValid && opValue[15:5] == 11'h000;
    endproperty
    a_lit5: assert property (p_lit5)
        else $error("short literal too wide");

    property p_bus;
        (avsRead || avsWrite) && !busAck |=> !avsWaitrequest ##1 !busAck;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus answer not after one cycle");
endmodule // eag_core

// [tb/eag_decoder_model.sv]
// Decoder model: issues address requests and working register writes
// Assumes the core takes each request at a rising clock edge
`timescale 1ns/1ps
module eag_decoder_model
    import eag_pkg::*;
(
    input wire logic clock,
    output logic reqValid = 1'h0,
    output eag_mode_t reqMode = MD_IND,
    output eag_stack_t reqStack = STK_NONE,
    output eag_push_t reqPushSrc = PUSH_OPERAND,
    output logic [3:0] reqPtr = 4'h0,
    output logic [3:0] reqIdx = 4'h0,
    output logic [15:0] reqField = 16'h0000,
    output logic regWrValid = 1'h0,
    output logic [3:0] regWrIdx = 4'h0,
    output logic [15:0] regWrData = 16'h0000
);
    // ======
    // One-cycle requests; no stack read right after a limit write
    task automatic issue(input eag_mode_t m, input eag_stack_t s,
        input eag_push_t p, input logic [3:0] ptr, input logic [3:0] idx,
        input logic [15:0] f);
        @(posedge clock);
        reqValid <= 1'h1;
        reqMode <= m;
        reqStack <= s;
        reqPushSrc <= p;
        reqPtr <= ptr;
        reqIdx <= idx;
        reqField <= f;
        @(posedge clock);
        reqValid <= 1'h0;
        reqField <= ~f;
    endtask
    task automatic setReg(input logic [3:0] i, input logic [15:0] d);
        @(posedge clock);
        regWrValid <= 1'h1;
        regWrIdx <= i;
        regWrData <= d;
        @(posedge clock);
        regWrValid <= 1'h0;
        regWrData <= ~d;
    endtask
endmodule // eag_decoder_model

// [tb/testbench.sv]
// Self-checking bench for the effective address generator
// Assumes the decoder model drives requests, this bench the register bus
`timescale 1ns/1ps
module testbench
    import eag_pkg::*;
;
    logic clock = 1'h0, rst_n = 1'h0, avsRead = 1'h0, avsWrite = 1'h0;
    logic [4:0] avsAddress = 5'h00;
    logic [31:0] avsWritedata = 32'h0, avsReaddata;
    logic [23:0] pcValue = 24'h0;
    logic [7:0] statusLow = 8'h00;
    logic codeInBoot = 1'h0, codeInSecure = 1'h0;
    logic avsWaitrequest, reqValid, regWrValid, eaValid, eaSpaceY, eaDenied;
    logic opValid, stackErrTrap, modeError;
    eag_mode_t reqMode;
    eag_stack_t reqStack;
    eag_push_t reqPushSrc;
    logic [3:0] reqPtr, reqIdx, regWrIdx;
    logic [15:0] reqField, regWrData, eaAddr, pushData, opValue, q, p, f, lim;
    int errors = 0, samplesChecked = 0;
    eag_mode_t ms[3] = '{MD_POST, MD_PRE, MD_LITOFS};
    eag_mode_t lm[6] = '{MD_LIT5, MD_LIT8, MD_LIT16, MD_BRANCH, MD_IRQ_DIS,
        MD_REG};
    always #12.5 clock = ~clock;
    eag_core uut(.clock, .rst_n, .avsAddress, .avsRead, .avsWrite,
        .avsWritedata, .avsByteenable(4'h3), .avsReaddata, .avsWaitrequest,
        .reqValid, .reqMode, .reqStack, .reqPushSrc, .reqPtr, .reqIdx,
        .reqField, .reqOperand(16'h5A5A), .pcValue, .statusLow, .codeInBoot,
        .codeInSecure, .regWrValid, .regWrIdx, .regWrData, .eaValid,
        .eaAddr, .eaSpaceY, .eaDenied, .pushData, .opValid, .opValue,
        .stackErrTrap, .modeError);
    eag_decoder_model dec(.clock, .reqValid, .reqMode, .reqStack,
        .reqPushSrc, .reqPtr, .reqIdx, .reqField, .regWrValid, .regWrIdx,
        .regWrData);
    // ======
    // Checking and bus tasks
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        samplesChecked++;
        if (s !== e)
        begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic complete_run;
        if (errors == 0 && samplesChecked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [15:0] d);
        @(posedge clock);
        avsAddress <= a;
        avsWrite <= w;
        avsRead <= !w;
        avsWritedata <= {16'h0000, d};
        @(posedge clock);
        while (avsWaitrequest !== 1'h0)
            @(posedge clock);
        q = avsReaddata[15:0];
        avsRead <= 1'h0;
        avsWrite <= 1'h0;
    endtask
    function automatic logic [15:0] wrap(input logic [15:0] a);
        return a > 16'h100F ? a - 16'h0010 : a < 16'h1000 ? a + 16'h0010 : a;
    endfunction
    function automatic logic [15:0] lit(input eag_mode_t m,
        input logic [15:0] v);
        case (m)
            MD_LIT5: return v & 16'h001F;
            MD_LIT8: return v & 16'h00FF;
            MD_IRQ_DIS: return v & 16'h3FFF;
            MD_REG: return ~v;
            default: return v;
        endcase
    endfunction
    task automatic ea(input eag_mode_t m, input eag_stack_t s,
        input logic [3:0] ptr, input logic [15:0] fl, input logic [15:0] e);
        dec.issue(m, s, PUSH_OPERAND, ptr, 4'h0, fl);
        #1;
        chk(eaAddr, e);
        chk({15'h0, stackErrTrap},
            {15'h0, ptr == SP_REG && (e > lim || e < UNDERFLOW_LIMIT)});
    endtask
    task automatic dual(input eag_mode_t m, input logic [3:0] ptr,
        input logic [15:0] fl, input logic [1:0] e);
        dec.issue(m, STK_NONE, PUSH_OPERAND, ptr, 4'h0, fl);
        #1;
        chk({13'h0, eaValid, modeError, eaSpaceY}, {13'h0, !e[1], e});
    endtask
    // ======
    // Main sequence
    initial
    begin
        void'($urandom(25291));
        repeat (16) @(posedge clock);
        rst_n <= 1'h1;
        bus(1'h0, OFS_STACK_PTR, 16'h0);
        chk(q, SP_RESET);
        bus(1'h0, OFS_CIRC_CONTROL, 16'h0);
        chk(q, CC_RESET);
        bus(1'h0, 5'h02, 16'h0);
        chk(q, 16'h0000);
        bus(1'h1, OFS_STACK_LIMIT, 16'h0805);
        bus(1'h0, OFS_STACK_LIMIT, 16'h0);
        chk(q, 16'h0804);
        lim = 16'h0804;
        for (int i = 0; i < 4; i++)
            ea(MD_IND, STK_PUSH, SP_REG, 16'h0, 16'h0800 + 16'(2 * i));
        bus(1'h0, OFS_STACK_PTR, 16'h0);
        chk(q, 16'h0808);
        for (int i = 0; i < 5; i++)
            ea(MD_IND, STK_POP, SP_REG, 16'h0, 16'h0806 - 16'(2 * i));
        ea(MD_IND, STK_NONE, SP_REG, 16'h0, 16'h07FE);
        bus(1'h1, OFS_STACK_LIMIT, 16'h0FFE);
        lim = 16'h0FFE;
        dec.setReg(SP_REG, 16'h0810);
        @(posedge clock);
        pcValue <= 24'($urandom) | 24'h800000;
        statusLow <= 8'($urandom);
        for (int k = 1; k < 4; k++)
        begin
            dec.issue(MD_IND, STK_PUSH, eag_push_t'(k), SP_REG, 4'h0, 16'h0);
            #1;
            if (k == 1)
                chk(pushData, pcValue[15:0]);
            else if (k == 2)
                chk(pushData, {9'h000, pcValue[22:16]});
            else
                chk(pushData, {statusLow, pcValue[23:16]});
        end
        for (int n = 0; n < 60; n++)
        begin
            p = 16'($urandom) & 16'hFFFE;
            f = 16'($urandom) & 16'h001E;
            dec.setReg(4'h3, p);
            ea(ms[n % 3], STK_NONE, 4'h3, f, n % 3 == 0 ? p : p + f);
            ea(MD_IND, STK_NONE, 4'h3, 16'h0, n % 3 == 2 ? p : p + f);
        end
        dec.setReg(4'h5, f);
        dec.issue(MD_REGOFS, STK_NONE, PUSH_OPERAND, 4'h3, 4'h5, ~f);
        #1;
        chk(eaAddr, p + f);
        for (int n = 0; n < 30; n++)
        begin
            f = 16'($urandom);
            dec.setReg(4'h3, ~f);
            dec.issue(lm[n % 6], STK_NONE, PUSH_OPERAND, 4'h3, 4'h0, f);
            #1;
            chk(opValue, lit(lm[n % 6], f));
            chk({15'h0, opValid}, 16'h0001);
        end
        ea(MD_FILE, STK_NONE, 4'h0, 16'hFFFF, 16'h1FFF);
        bus(1'h1, OFS_X_CIRC_START, 16'h1000);
        bus(1'h1, OFS_X_CIRC_END, 16'h100F);
        bus(1'h1, OFS_CIRC_CONTROL, 16'h80F2);
        dec.setReg(4'h2, 16'h100E);
        ea(MD_POST, STK_NONE, 4'h2, 16'h0002, 16'h100E);
        ea(MD_PRE, STK_NONE, 4'h2, 16'hFFFE, wrap(16'h0FFE));
        ea(MD_POST, STK_NONE, 4'h2, 16'h0004, 16'h100E);
        ea(MD_IND, STK_NONE, 4'h2, 16'h0, wrap(16'h1012));
        dual(MD_DUAL_POST, 4'h8, 16'h0003, 2'h2);
        dual(MD_DUAL_POST, Y_PREFETCH_A, 16'h0006, 2'h1);
        dual(MD_DUAL_IND, 4'h4, 16'h0, 2'h2);
        dual(MD_DUAL_IDX, 4'h8, 16'h0, 2'h2);
        dual(MD_DUAL_IDX, Y_PREFETCH_B, 16'h0, 2'h1);
        bus(1'h1, OFS_SECURE_CTRL, 16'h0003);
        dec.setReg(4'h4, BOOT_RAM_LO);
        dec.setReg(4'h5, SEG_RAM_HI);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clock);
            codeInBoot <= k[0];
            codeInSecure <= k[1];
            dec.issue(MD_IND, STK_NONE, PUSH_OPERAND, 4'h4, 4'h0, 16'h0);
            #1;
            chk({15'h0, eaDenied}, {15'h0, !k[0]});
            dec.issue(MD_IND, STK_NONE, PUSH_OPERAND, 4'h5, 4'h0, 16'h0);
            #1;
            chk({15'h0, eaDenied}, {15'h0, !k[1]});
        end
        complete_run;
    end
    initial
    begin
        #(25 * 20000);
        errors++;
        complete_run;
    end
endmodule // testbench
